/* design/bmsup_map.svh */
// constant map of the braking module supervisor: offsets, fields, resets, timing
`ifndef BMSUP_MAP_SVH
`define BMSUP_MAP_SVH
// ==========================================================================
// register byte offsets
`define BMSUP_OFS_CTRL     12'h000
`define BMSUP_OFS_DELAY    12'h004
`define BMSUP_OFS_STATUS   12'h008
`define BMSUP_OFS_IRQ_STAT 12'h00C
`define BMSUP_OFS_IRQ_MASK 12'h010
`define BMSUP_OFS_INPUTS   12'h014
// ==========================================================================
// ctrl fields
`define BMSUP_CTRL_ENABLE   0
`define BMSUP_CTRL_BOOKSIZE 1
`define BMSUP_CTRL_FB_USED  2
`define BMSUP_CTRL_CNT_LSB  4
`define BMSUP_CTRL_CNT_MSB  7
// status fields
`define BMSUP_ST_ACTIVE     0
`define BMSUP_ST_ALARM      1
`define BMSUP_ST_DISCHARGE  2
`define BMSUP_ST_CONTACTOR  3
`define BMSUP_ST_STATE_LSB  4
`define BMSUP_ST_STATE_MSB  5
// interrupt event bits
`define BMSUP_EV_ALARM      0
`define BMSUP_EV_PREALARM   1
`define BMSUP_EV_DIS_START  2
`define BMSUP_EV_DIS_END    3
`define BMSUP_EV_ABORT      4
`define BMSUP_EV_W          5
// ==========================================================================
// reset values
`define BMSUP_CTRL_RST      32'h0000_0086
`define BMSUP_DELAY_RST     32'h0000_0064
// ==========================================================================
// timing
`define BMSUP_CLK_HZ        20000000
`define BMSUP_ACK_PERIOD_MS 10
`define BMSUP_ACK_CYCLES    ((`BMSUP_CLK_HZ / 1000) * `BMSUP_ACK_PERIOD_MS)
`define BMSUP_ACK_PULSE     1000
`define BMSUP_DELAY_TICK_US 1000
`define BMSUP_TICK_CYCLES   ((`BMSUP_CLK_HZ / 1000000) * `BMSUP_DELAY_TICK_US)
`endif

/* design/bmsup_pkg.sv */
// types shared by the braking module supervisor modules
package bmsup_pkg;
  // ==========================================================================
  // discharge sequencer states, gray along idle, wait open, delay, discharge
  typedef enum logic [1:0] {
    BMSUP_IDLE   = 2'b00,
    BMSUP_WAIT   = 2'b01,
    BMSUP_DELAY  = 2'b11,
    BMSUP_DISCH  = 2'b10
  } bmsup_state_t;
endpackage : bmsup_pkg

/* design/bmsup_tick_if.sv */
// shared timebase between bmsup_timebase and the ack retry engine
interface bmsup_tick_if;
  logic ack_tick;
  logic ack_on;
  modport src (output ack_tick, output ack_on);
  modport dst (input ack_tick, input ack_on);
endinterface : bmsup_tick_if

/* design/bmsup_timebase.sv */
// free running 10 ms retry timebase with acknowledge pulse window
`include "bmsup_map.svh"
module bmsup_timebase #(
  parameter int PERIOD = `BMSUP_ACK_CYCLES,
  parameter int PULSE  = `BMSUP_ACK_PULSE
) (
  input  wire logic   clk_sys_i,
  input  wire logic   resetn_i,
  bmsup_tick_if.src   tb
);
  initial begin
    if (PULSE < 1 || PULSE >= PERIOD) $error("bmsup_timebase: bad pulse");
  end
  logic [31:0] cnt;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 32'h0;
    end else if (cnt == 32'(PERIOD - 1)) begin
      cnt <= 32'h0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end
  assign tb.ack_tick = (cnt == 32'h0);
  assign tb.ack_on   = (cnt < 32'(PULSE));
endmodule : bmsup_timebase

/* design/bmsup_ack.sv */
// per-slot acknowledge retry engine
`include "bmsup_map.svh"
module bmsup_ack #(
  parameter int N = 8
) (
  input  wire logic          clk_sys_i,
  input  wire logic          resetn_i,
  bmsup_tick_if.dst          tb,
  input  wire logic [N-1:0]  slot_en_i,
  input  wire logic [N-1:0]  fault_i,
  output logic      [N-1:0]  retry_o
);
  // ==========================================================================
  // an attempt is armed at a 10 ms tick and held for the pulse window while its slot stays enabled and faulty
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      retry_o <= '0;
    end else if (tb.ack_tick) begin
      retry_o <= fault_i & slot_en_i;
    end else if (!tb.ack_on) begin
      retry_o <= '0;
    end else begin
      retry_o <= retry_o & fault_i & slot_en_i;
    end
  end
endmodule : bmsup_ack

/* design/bmsup_top.sv */
// braking module supervisor: fault ack retries, alarm, fast dc link discharge
`include "bmsup_map.svh"
module bmsup_top #(
  parameter int NUM_UNITS  = 8,
  parameter int ACK_CYCLES = `BMSUP_ACK_CYCLES,
  parameter int ACK_PULSE  = `BMSUP_ACK_PULSE,
  parameter int TICK_CYC   = `BMSUP_TICK_CYCLES
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  resetn_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic [NUM_UNITS-1:0]  unit_fault_in_i,
  input  wire logic [NUM_UNITS-1:0]  unit_prealarm_in_i,
  input  wire logic                  discharge_activate_in_i,
  input  wire logic                  contactor_feedback_in_i,
  output logic      [NUM_UNITS-1:0]  unit_inhibit_ack_out_o,
  output logic      [NUM_UNITS-1:0]  unit_discharge_out_o,
  output logic                       contactor_control_out_o,
  output logic                       braking_unit_alarm_o,
  output logic                       irq_o
);
  initial begin
    if (NUM_UNITS < 1 || NUM_UNITS > 8) $error("bmsup_top: NUM_UNITS must be 1..8");
    if (TICK_CYC < 1) $error("bmsup_top: TICK_CYC must be positive");
  end
  // ==========================================================================
  // registers
  logic [31:0]               ctrl;
  logic [15:0]               delay_set;
  logic [`BMSUP_EV_W-1:0]    irq_stat;
  logic [`BMSUP_EV_W-1:0]    irq_mask;
  logic [`BMSUP_EV_W-1:0]    ev;
  logic [NUM_UNITS-1:0]      slot_en;
  logic [NUM_UNITS-1:0]      retry;
  logic [NUM_UNITS-1:0]      prealarm_q;
  bmsup_pkg::bmsup_state_t   state;
  logic [15:0]               dcnt;
  logic [31:0]               tcnt;
  logic                      alarm_q;
  logic                      wr;
  logic                      dis_allowed;
  logic                      enable;
  logic                      booksize;
  logic                      fb_used;
  logic                      contactor_open;
  logic                      fault_any;

  function automatic logic [NUM_UNITS-1:0] slot_mask(input logic [3:0] cnt);
    logic [NUM_UNITS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_UNITS; i++) begin
      if (4'(i) < cnt) m[i] = 1'b1;
    end
    return m;
  endfunction : slot_mask

  assign enable         = ctrl[`BMSUP_CTRL_ENABLE];
  assign booksize       = ctrl[`BMSUP_CTRL_BOOKSIZE];
  assign fb_used        = ctrl[`BMSUP_CTRL_FB_USED];
  assign slot_en        = enable ? slot_mask(ctrl[`BMSUP_CTRL_CNT_MSB:`BMSUP_CTRL_CNT_LSB]) : '0;
  assign contactor_open = !contactor_feedback_in_i;
  assign fault_any      = |(unit_fault_in_i & slot_en);
  assign wr             = psel_i && penable_i && pwrite_i;
  assign dis_allowed    = enable && booksize && fb_used;

  // ==========================================================================
  // timebase and ack engine
  bmsup_tick_if tbif ();
  bmsup_timebase #(.PERIOD(ACK_CYCLES), .PULSE(ACK_PULSE)) u_tb (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .tb        (tbif)
  );
  bmsup_ack #(.N(NUM_UNITS)) u_ack (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .tb        (tbif),
    .slot_en_i (slot_en),
    .fault_i   (unit_fault_in_i),
    .retry_o   (retry)
  );

  // ==========================================================================
  // config registers
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl      <= `BMSUP_CTRL_RST;
      delay_set <= 16'(`BMSUP_DELAY_RST);
      irq_mask  <= '0;
    end else if (wr) begin
      case (paddr_i)
        `BMSUP_OFS_CTRL:     ctrl      <= {24'h0, pwdata_i[7:4] > 4'h8 ? 4'h8 : pwdata_i[7:4], 1'b0, pwdata_i[2:0]};
        `BMSUP_OFS_DELAY:    delay_set <= pwdata_i[15:0];
        `BMSUP_OFS_IRQ_MASK: irq_mask  <= pwdata_i[`BMSUP_EV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // alarm: raised with the first attempt, held until no fault remains
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm_q <= 1'b0;
    end else if (!fault_any) begin
      alarm_q <= 1'b0;
    end else if (|retry) begin
      alarm_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prealarm_q <= '0;
    end else begin
      prealarm_q <= unit_prealarm_in_i & slot_en;
    end
  end

  // ==========================================================================
  // discharge sequencer; delay counted in 1 ms ticks
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= bmsup_pkg::BMSUP_IDLE;
      dcnt  <= 16'h0;
      tcnt  <= 32'h0;
    end else begin
      case (state)
        bmsup_pkg::BMSUP_IDLE: begin
          if (discharge_activate_in_i && dis_allowed) begin
            state <= bmsup_pkg::BMSUP_WAIT;
          end
        end
        bmsup_pkg::BMSUP_WAIT: begin
          // a config write that drops booksize or feedback use also abandons a pending start
          if (!discharge_activate_in_i || !dis_allowed) begin
            state <= bmsup_pkg::BMSUP_IDLE;
          end else if (contactor_open) begin
            state <= bmsup_pkg::BMSUP_DELAY;
            dcnt  <= 16'h0;
            tcnt  <= 32'h0;
          end
        end
        bmsup_pkg::BMSUP_DELAY: begin
          if (!discharge_activate_in_i || !contactor_open || !dis_allowed) begin
            state <= bmsup_pkg::BMSUP_IDLE;
          end else if (dcnt >= delay_set) begin
            state <= bmsup_pkg::BMSUP_DISCH;
          end else if (tcnt == 32'(TICK_CYC - 1)) begin
            tcnt <= 32'h0;
            dcnt <= dcnt + 16'h1;
          end else begin
            tcnt <= tcnt + 32'h1;
          end
        end
        bmsup_pkg::BMSUP_DISCH: begin
          if (!contactor_open) begin
            state <= bmsup_pkg::BMSUP_IDLE;
          end
        end
        default: state <= bmsup_pkg::BMSUP_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // pin outputs, registered
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      unit_inhibit_ack_out_o  <= '0;
      unit_discharge_out_o    <= '0;
      contactor_control_out_o <= 1'b0;
      braking_unit_alarm_o    <= 1'b0;
    end else begin
      unit_inhibit_ack_out_o  <= retry;
      unit_discharge_out_o    <= (state == bmsup_pkg::BMSUP_DISCH && contactor_open) ? slot_en : '0;
      // contactor held open while a discharge is pending or running
      contactor_control_out_o <= enable && state == bmsup_pkg::BMSUP_IDLE;
      braking_unit_alarm_o    <= alarm_q;
    end
  end

  // ==========================================================================
  // interrupts: set wins over write-one-to-clear
  always_comb begin
    ev = '0;
    ev[`BMSUP_EV_ALARM]     = |retry && !alarm_q && fault_any;
    ev[`BMSUP_EV_PREALARM]  = |(unit_prealarm_in_i & slot_en & ~prealarm_q);
    ev[`BMSUP_EV_DIS_START] = state == bmsup_pkg::BMSUP_DELAY && dcnt >= delay_set
                              && discharge_activate_in_i && contactor_open;
    ev[`BMSUP_EV_DIS_END]   = state == bmsup_pkg::BMSUP_DISCH && !contactor_open;
    ev[`BMSUP_EV_ABORT]     = (state == bmsup_pkg::BMSUP_WAIT || state == bmsup_pkg::BMSUP_DELAY)
                              && (!discharge_activate_in_i || !dis_allowed);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat <= '0;
    end else if (wr && paddr_i == `BMSUP_OFS_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~pwdata_i[`BMSUP_EV_W-1:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================================
  // apb read side; zero wait states, unmapped gives slverr
  // ready from a flop that stays high, so every access phase ends at its first edge
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b1;
    end else begin
      pready_o <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      pslverr_o <= 1'b0;
      case (paddr_i)
        `BMSUP_OFS_CTRL:     prdata_o <= ctrl;
        `BMSUP_OFS_DELAY:    prdata_o <= {16'h0, delay_set};
        `BMSUP_OFS_STATUS:   prdata_o <= {26'h0, state, contactor_feedback_in_i,
                                          state == bmsup_pkg::BMSUP_DISCH, alarm_q, enable};
        `BMSUP_OFS_IRQ_STAT: prdata_o <= {27'h0, irq_stat};
        `BMSUP_OFS_IRQ_MASK: prdata_o <= {27'h0, irq_mask};
        `BMSUP_OFS_INPUTS:   prdata_o <= {16'h0, 8'(unit_prealarm_in_i), 8'(unit_fault_in_i)};
        default: begin
          prdata_o  <= 32'h0;
          pslverr_o <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // checks
  AST_NO_DIS_NOT_BOOK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !booksize |-> ##1 state == $past(state) || state == bmsup_pkg::BMSUP_IDLE || $past(state) != bmsup_pkg::BMSUP_IDLE)
    else $error("discharge sequence entered without booksize");
  AST_DIS_END: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !contactor_open |=> unit_discharge_out_o == '0)
    else $error("discharge outputs active with contactor closed");
  AST_ACK_NEEDS_FAULT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(tbif.ack_tick) && fault_any |=> |retry)
    else $error("no acknowledge attempt at tick");
  AST_ALARM_CLR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !fault_any |=> !alarm_q)
    else $error("alarm held without fault");
  // ==========================================================================
  // checks: acknowledge engine, alarm, discharge sequencer
  AST_ACK_WINDOW: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !tbif.ack_on |=> retry == '0)
    else $error("acknowledge attempt outside the pulse window");
  AST_ALARM_WITH_RETRY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    |retry && fault_any |=> alarm_q)
    else $error("alarm not raised with the acknowledge attempt");
  AST_RETRY_IN_SLOTS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    tbif.ack_tick |=> (retry & ~$past(slot_en)) == '0)
    else $error("acknowledge attempt on an unconfigured slot");
  AST_DIS_ONLY_IN_DISCH: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    state != bmsup_pkg::BMSUP_DISCH |=> unit_discharge_out_o == '0)
    else $error("discharge outputs active before the delay expired");
  AST_NO_START_WITHOUT_FB: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !fb_used && state == bmsup_pkg::BMSUP_IDLE |=> state == bmsup_pkg::BMSUP_IDLE)
    else $error("discharge sequence entered without contactor feedback");
  AST_CTL_OPEN_WHEN_BUSY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    state != bmsup_pkg::BMSUP_IDLE |=> !contactor_control_out_o)
    else $error("contactor commanded closed during a discharge sequence");
  AST_DELAY_ABORT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state == bmsup_pkg::BMSUP_WAIT || state == bmsup_pkg::BMSUP_DELAY) && !discharge_activate_in_i
    |=> state == bmsup_pkg::BMSUP_IDLE)
    else $error("pending discharge not abandoned after activation dropped");
endmodule : bmsup_top

/* test/bmsup_unit_model.sv */
// model of the braking units and the line contactor at the supervisor's terminals
module bmsup_unit_model #(
  parameter int N = 8
) (
  input  wire logic          clk_sys_i,
  input  wire logic          resetn_i,
  input  wire logic [N-1:0]  ack_i,
  input  wire logic          ctl_i,
  input  wire logic [N-1:0]  fault_cmd_i,
  input  wire logic [N-1:0]  clear_on_ack_i,
  input  wire logic [N-1:0]  prealarm_cmd_i,
  input  wire logic          force_close_i,
  output logic      [N-1:0]  fault_o,
  output logic      [N-1:0]  prealarm_o,
  output logic               feedback_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [N-1:0] ack_q;
  logic [N-1:0] cleared;
  logic [2:0]   ctl_q;
  // ==========================================================================
  // units: a fault may go away at the end of an acknowledge pulse
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q   <= '0;
      cleared <= '0;
    end else begin
      ack_q   <= ack_i;
      cleared <= fault_cmd_i & (cleared | (ack_q & ~ack_i & clear_on_ack_i));
    end
  end
  assign fault_o    = fault_cmd_i & ~cleared;
  assign prealarm_o = prealarm_cmd_i;
  // ==========================================================================
  // contactor: mechanical lag of three cycles; manual close overrides
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_q <= 3'h0;
    end else begin
      ctl_q <= {ctl_q[1:0], ctl_i};
    end
  end
  assign feedback_o = ctl_q[2] | force_close_i;
endmodule : bmsup_unit_model

/* test/bmsup_top_tb.sv */
// self-checking bench of the braking module supervisor
`include "bmsup_map.svh"
module bmsup_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ACK_CYC = 100;
  localparam int ACK_PUL = 10;
  localparam int TICK    = 5;
  logic        clk_sys_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  fault, prealarm, ack, dis;
  logic [7:0]  fault_cmd = 8'h00;
  logic [7:0]  clr_ack = 8'h00;
  logic [7:0]  pre_cmd = 8'h00;
  logic        act = 1'b0;
  logic        force_close = 1'b0;
  logic        fb, ctl, alarm, irq;
  logic [31:0] q;
  logic        e;
  logic [7:0]  acc_ack, acc_dis;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          n;
  always #25 clk_sys_i = ~clk_sys_i;
  bmsup_top #(.ACK_CYCLES(ACK_CYC), .ACK_PULSE(ACK_PUL), .TICK_CYC(TICK)) i_bmsup_top (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .unit_fault_in_i(fault),
    .unit_prealarm_in_i(prealarm), .discharge_activate_in_i(act), .contactor_feedback_in_i(fb),
    .unit_inhibit_ack_out_o(ack), .unit_discharge_out_o(dis), .contactor_control_out_o(ctl),
    .braking_unit_alarm_o(alarm), .irq_o(irq));
  bmsup_unit_model i_bmsup_unit_model (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ack_i(ack), .ctl_i(ctl), .fault_cmd_i(fault_cmd),
    .clear_on_ack_i(clr_ack), .prealarm_cmd_i(pre_cmd), .force_close_i(force_close),
    .fault_o(fault), .prealarm_o(prealarm), .feedback_o(fb));
  // ==========================================================================
  // common tasks
  task conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask : cyc
  // one apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdmask(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q & m, exp);
  endtask : rdmask
  task watch(input int k);
    acc_ack = 8'h00;
    acc_dis = 8'h00;
    repeat (k) begin
      cyc(1);
      acc_ack = acc_ack | ack;
      acc_dis = acc_dis | dis;
    end
  endtask : watch
  // a hang ends the run as a failure
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  // ==========================================================================
  // scenarios
  initial begin
    cyc(10);
    resetn_i <= 1'b1;
    rdmask(`BMSUP_OFS_CTRL, 32'hFFFFFFFF, 32'h0000_0086);
    rdmask(`BMSUP_OFS_DELAY, 32'hFFFFFFFF, 32'h0000_0064);
    apb(1'b0, 12'hFFC, 32'h0);
    check({q[30:0], e}, 32'h0000_0001);
    rdmask(`BMSUP_OFS_STATUS, 32'h1, 32'h0);
    apb(1'b1, `BMSUP_OFS_CTRL, 32'h0000_00F7);
    rdmask(`BMSUP_OFS_CTRL, 32'hFF, 32'h0000_0087);
    rdmask(`BMSUP_OFS_STATUS, 32'h1, 32'h1);
    apb(1'b1, `BMSUP_OFS_IRQ_MASK, 32'h0000_0001);
    clr_ack <= 8'h20;
    fault_cmd <= 8'h24;
    n = 0;
    while (ack[2] !== 1'b1 && n < 300) begin cyc(1); n++; end
    check(ack, 8'h24);
    n = 0;
    while (ack[2] === 1'b1 && n < 50) begin cyc(1); n++; end
    check(n, ACK_PUL);
    check({alarm, irq}, 2'b11);
    while (ack[2] !== 1'b1 && n < 300) begin cyc(1); n++; end
    check(n, ACK_CYC);
    check(ack, 8'h04);
    rdmask(`BMSUP_OFS_STATUS, 32'h2, 32'h2);
    apb(1'b1, `BMSUP_OFS_IRQ_STAT, 32'h0000_0001);
    cyc(2);
    check(irq, 1'b0);
    fault_cmd <= 8'h00;
    cyc(5);
    check(alarm, 1'b0);
    watch(150);
    check(acc_ack, 8'h00);
    pre_cmd <= 8'h01;
    cyc(3);
    rdmask(`BMSUP_OFS_IRQ_STAT, 32'h2, 32'h2);
    pre_cmd <= 8'h00;
    // no discharge for a non-booksize unit or without contactor feedback
    apb(1'b1, `BMSUP_OFS_DELAY, 32'h0000_0004);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `BMSUP_OFS_CTRL, (i == 0) ? 32'h0000_0035 : 32'h0000_0033);
      act <= 1'b1;
      watch(80);
      act <= 1'b0;
      check(acc_dis, 8'h00);
      cyc(10);
    end
    apb(1'b1, `BMSUP_OFS_CTRL, 32'h0000_0037);
    cyc(10);
    act <= 1'b1;
    n = 0;
    while (fb !== 1'b0 && n < 50) begin cyc(1); n++; end
    check(ctl, 1'b0);
    n = 0;
    while (dis === 8'h00 && n < 100) begin cyc(1); n++; end
    check(n >= 4 * TICK && n <= 4 * TICK + 3, 1'b1);
    check(dis, 8'h07);
    rdmask(`BMSUP_OFS_STATUS, 32'h4, 32'h4);
    force_close <= 1'b1;
    n = 0;
    while (dis !== 8'h00 && n < 20) begin cyc(1); n++; end
    check(n < 5, 1'b1);
    act <= 1'b0;
    force_close <= 1'b0;
    cyc(10);
    rdmask(`BMSUP_OFS_IRQ_STAT, 32'hC, 32'hC);
    // clear all events: activation still high at the end re-armed and aborted once
    apb(1'b1, `BMSUP_OFS_IRQ_STAT, 32'h0000_001F);
    // activation dropped while the delay runs
    act <= 1'b1;
    n = 0;
    while (fb !== 1'b0 && n < 50) begin cyc(1); n++; end
    cyc(5);
    act <= 1'b0;
    watch(60);
    check(acc_dis, 8'h00);
    rdmask(`BMSUP_OFS_IRQ_STAT, 32'h14, 32'h10);
    rdmask(`BMSUP_OFS_STATUS, 32'h30, 32'h0);
    conclude();
  end
endmodule : bmsup_top_tb
